// [core/rtcca_cal.sv]
// next-second calendar arithmetic on the time bytes
`timescale 1ns/10ps
`include "rtcca_params.svh"
module rtcca_cal (
   // current bytes and mode
   input wire logic [9:0][7:0] cur,
   input wire logic bin_mode,
   input wire logic h24,
   // bytes one second later, alarms unchanged
   output logic [9:0][7:0] nxt
);
   logic [7:0] s, m, h, h12, wd, d, mo, yr, eh;

   function automatic logic [7:0] to_bin(input logic [7:0] v,
                                         input logic bin);
      to_bin = bin ? v : ({4'h0, v[7:4]} * 8'h0a) + {4'h0, v[3:0]};
   endfunction : to_bin

   function automatic logic [7:0] to_enc(input logic [7:0] b,
                                         input logic bin);
      logic [7:0] t;
      logic [7:0] u;
      t = b / 8'h0a;
      u = b % 8'h0a;
      to_enc = bin ? b : {t[3:0], u[3:0]};
   endfunction : to_enc

   function automatic logic [7:0] mdays(input logic [7:0] mon,
                                        input logic [7:0] year);
      if (mon == 8'h02) begin
         mdays = (year[1:0] == 2'h0) ? 8'h1d : 8'h1c;
      end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 ||
                   mon == 8'h0b) begin
         mdays = 8'h1e;
      end else begin
         mdays = 8'h1f;
      end
   endfunction : mdays

   always_comb begin
      nxt = cur;
      s = to_bin(cur[`RTCCA_OFS_SEC], bin_mode); // R23
      m = to_bin(cur[`RTCCA_OFS_MIN], bin_mode);
      h12 = to_bin({1'b0, cur[`RTCCA_OFS_HOUR][6:0]}, bin_mode);
      h = h24 ? to_bin(cur[`RTCCA_OFS_HOUR], bin_mode) :
         ((h12 == 8'h0c) ? 8'h00 : h12) +
         (cur[`RTCCA_OFS_HOUR][7] ? 8'h0c : 8'h00); // R1
      wd = cur[`RTCCA_OFS_WDAY];
      d = to_bin(cur[`RTCCA_OFS_DATE], bin_mode);
      mo = to_bin(cur[`RTCCA_OFS_MONTH], bin_mode);
      yr = to_bin(cur[`RTCCA_OFS_YEAR], bin_mode);
      if (s < 8'h3b) begin // R5
         s = s + 8'h01;
      end else begin
         s = 8'h00;
         if (m < 8'h3b) begin
            m = m + 8'h01;
         end else begin
            m = 8'h00;
            if (h < 8'h17) begin
               h = h + 8'h01;
            end else begin
               h = 8'h00;
               wd = (wd >= 8'h07) ? 8'h01 : wd + 8'h01; // R6
               if (d < mdays(mo, yr)) begin // R27
                  d = d + 8'h01;
               end else begin
                  d = 8'h01;
                  if (mo < 8'h0c) begin
                     mo = mo + 8'h01;
                  end else begin
                     mo = 8'h01;
                     yr = (yr >= 8'h63) ? 8'h00 : yr + 8'h01;
                  end
               end
            end
         end
      end
      h12 = (h >= 8'h0c) ? h - 8'h0c : h;
      if (h12 == 8'h00) begin
         h12 = 8'h0c;
      end
      eh = to_enc(h12, bin_mode);
      nxt[`RTCCA_OFS_SEC] = to_enc(s, bin_mode);
      nxt[`RTCCA_OFS_MIN] = to_enc(m, bin_mode);
      nxt[`RTCCA_OFS_HOUR] = h24 ? to_enc(h, bin_mode) :
         {(h >= 8'h0c), eh[6:0]}; // R1
      nxt[`RTCCA_OFS_WDAY] = wd;
      nxt[`RTCCA_OFS_DATE] = to_enc(d, bin_mode);
      nxt[`RTCCA_OFS_MONTH] = to_enc(mo, bin_mode);
      nxt[`RTCCA_OFS_YEAR] = to_enc(yr, bin_mode);
   end
endmodule : rtcca_cal

// [core/rtcca_core.sv]
// rtc calendar core: bus slave, registers, divider chain, flags
`timescale 1ns/10ps
// Functional notes
// (R1) 12-hour mode: hours bit 7 set means PM, alarm too.
// (R2) each second advance the ten bytes, then test the alarm.
// (R3) alarm byte with top two bits set matches anything.
// (R4) wildcards give daily, hourly, per-minute or per-second alarms.
// (R5) seconds, minutes 0-59; hours, date, month, year in range.
// (R6) weekday counts 1 to 7, same code in both modes.
// (R7) general storage bytes always readable and writable.
// (R8) events set their flags whatever the enables say.
// (R9) enabling an already set flag asserts the request at once.
// (R10) flag read returns a stable snapshot, then clears set flags.
// (R11) events during a flag read are held and posted after it.
// (R12) request low while flag and enable both set; bit 7 mirrors.
// (R13) oscillator bits: 010 runs, 11x holds chain, others stop.
// (R14) one tap selector feeds square wave and periodic rate.
// (R15) square wave output only while its enable bit is set.
// (R16) periodic rate 122 us to 500 ms, request gated by enable.
// (R17) one update per second regardless of update inhibit.
// (R18) double buffer: inhibit freezes host copy, internal keeps counting.
// (R19) update-ended event follows each update.
// (R20) update pending rises 244 us before the update transfer.
// (R21) host sets inhibit before writing time, clears it afterwards.
// (R22) host rewrites hours after changing the 12/24 bit.
// (R23) data mode bit: one binary, zero bcd, for all ten bytes.
// (R24) setting update inhibit clears update-ended enable.
// (R25) reset clears flags and releases the request output.
// (R26) flag and battery registers are read-only.
// (R27) date rolls by month length, leap February every fourth year.
`include "rtcca_params.svh"
module rtcca_core #(
   parameter int unsigned TICK_STEP = `RTCCA_XTAL_HZ
) (
   // clock and reset
   input wire logic MCLK,
   input wire logic RST_N,
   // multiplexed host bus
   input wire logic [7:0] AD_I,
   output logic [7:0] AD_O,
   output logic AD_OE,
   input wire logic AS,
   input wire logic CS_N,
   input wire logic RD_N,
   input wire logic WR_N,
   // open-drain interrupt request
   output logic IRQ_N_O,
   output logic IRQ_OE,
   // square wave
   output logic SQUARE_WAVE_OUT
);
   localparam logic [14:0] UIP_START =
      `RTCCA_DIV_LAST - 15'(`RTCCA_UIP_LEAD_TICKS - 1);
   localparam rtcca_pkg::rtcca_state_t ST_RST = '{
      usr: `RTCCA_RST_TIME,
      itn: `RTCCA_RST_TIME,
      rega: `RTCCA_RST_CTRL_A,
      regb: `RTCCA_RST_CTRL_B,
      rd_p: 1'b1,
      wr_p: 1'b1,
      default: '0
   };

   rtcca_pkg::rtcca_state_t st_q;
   rtcca_pkg::rtcca_state_t st_d;
   logic [11:0] pin_s;
   logic [7:0] ad_s;
   logic as_s, cs_s, rd_s, wr_s, sel;
   logic rd_go, rd_end, wr_go;
   logic [9:0][7:0] nxt;
   logic [2:0] en, evt;
   logic [27:0] acc_sum;
   logic [3:0] rs, tap;
   logic irq, run, hold, tick, upd, update_pending_status, tap_lvl, alm_all;
   logic [7:0] rd_val, wv;

   // bus pins come from the host's domain
   rtcca_sync u_sync (
      .clk(MCLK),
      .rst_n(RST_N),
      .d({AS, CS_N, RD_N, WR_N, AD_I}),
      .q(pin_s)
   );
   assign as_s = pin_s[11];
   assign cs_s = pin_s[10];
   assign rd_s = pin_s[9];
   assign wr_s = pin_s[8];
   assign ad_s = pin_s[7:0];
   assign sel = !cs_s;
   assign rd_go = sel && st_q.rd_p && !rd_s;
   assign rd_end = !st_q.rd_p && rd_s;
   assign wr_go = sel && !st_q.wr_p && wr_s;

   rtcca_cal u_cal (
      .cur(st_q.itn),
      .bin_mode(st_q.regb[`RTCCA_B_BIN]),
      .h24(st_q.regb[`RTCCA_B_H24]),
      .nxt(nxt)
   );

   // rate code to divider stage; codes 1 and 2 alias 8 and 9
   function automatic logic [3:0] tap_of(input logic [3:0] code);
      if (code == 4'h1) begin
         tap_of = 4'h6;
      end else if (code == 4'h2) begin
         tap_of = 4'h7;
      end else begin
         tap_of = code - 4'h2;
      end
   endfunction : tap_of

   function automatic logic alm_hit(input logic [7:0] a,
                                    input logic [7:0] t);
      alm_hit = (a[7:6] == 2'h3) || (a == t);
   endfunction : alm_hit

   function automatic logic [7:0] reg_read(input logic [6:0] a);
      if (a < `RTCCA_OFS_CTRL_A) begin
         reg_read = st_q.usr[a[3:0]];
      end else if (a == `RTCCA_OFS_CTRL_A) begin
         reg_read = {update_pending_status, st_q.rega};
      end else if (a == `RTCCA_OFS_CTRL_B) begin
         reg_read = st_q.regb;
      end else if (a == `RTCCA_OFS_FLAGS) begin
         reg_read = {irq, st_q.flg, 4'h0}; // R12
      end else if (a == `RTCCA_OFS_BATT) begin
         reg_read = `RTCCA_BATT_OK;
      end else begin
         reg_read = st_q.nv[7'(a - `RTCCA_OFS_NV)]; // R7
      end
   endfunction : reg_read

   assign en = {st_q.regb[`RTCCA_B_PIE], st_q.regb[`RTCCA_B_AIE],
                st_q.regb[`RTCCA_B_UIE]};
   assign irq = |(st_q.flg & en); // R12 R9 R16
   assign run = st_q.rega[6:4] == `RTCCA_DV_RUN; // R13
   assign hold = st_q.rega[6:5] == `RTCCA_DV_HOLD; // R13
   // fractional step keeps the 32 kHz tick exact when MCLK runs at RTCCA_CLK_HZ (100 MHz)
   assign acc_sum = {1'b0, st_q.acc} + 28'(TICK_STEP);
   assign tick = acc_sum >= 28'(`RTCCA_CLK_HZ);
   assign upd = run && tick && (st_q.div == `RTCCA_DIV_LAST); // R17
   assign update_pending_status = run && !st_q.regb[`RTCCA_B_SET] &&
      (st_q.div >= UIP_START); // R20
   assign rs = st_q.rega[3:0];
   assign tap = tap_of(rs); // R14
   assign tap_lvl = (rs != 4'h0) && st_q.div[tap];
   assign alm_all = alm_hit(nxt[`RTCCA_OFS_SEC_ALM], nxt[`RTCCA_OFS_SEC])
      && alm_hit(nxt[`RTCCA_OFS_MIN_ALM], nxt[`RTCCA_OFS_MIN])
      && alm_hit(nxt[`RTCCA_OFS_HOUR_ALM], nxt[`RTCCA_OFS_HOUR]); // R3 R4
   // periodic, alarm, update-ended
   assign evt = {tap_lvl && !st_q.tap_p, upd && alm_all, upd}; // R19 R2
   assign rd_val = reg_read(st_q.addr);
   // top bit of seconds is read-only
   assign wv = (st_q.addr == `RTCCA_OFS_SEC) ? {1'b0, ad_s[6:0]} : ad_s;

   always_comb begin
      st_d = st_q;
      st_d.as_p = as_s;
      st_d.rd_p = rd_s;
      st_d.wr_p = wr_s;
      st_d.tap_p = tap_lvl;
      st_d.square_wave_out = st_q.regb[`RTCCA_B_SQUARE_WAVE_ENABLE] && tap_lvl; // R15
      st_d.acc = tick ? 27'(acc_sum - 28'(`RTCCA_CLK_HZ)) : acc_sum[26:0];
      // hold parks the chain half way, so the first update is 500 ms on
      if (hold) begin
         st_d.div = `RTCCA_DIV_HALF;
      end else if (run && tick) begin
         st_d.div = st_q.div + 15'h0001;
      end
      if (upd) begin
         st_d.itn = nxt; // R2 R18
         if (!st_q.regb[`RTCCA_B_SET]) begin
            st_d.usr = nxt; // R18
         end
      end
      // flags: events wait while a flag read is open
      if (st_q.c_busy) begin
         if (rd_end) begin
            st_d.flg = (st_q.flg & ~st_q.snap) | st_q.pend | evt; // R10
            st_d.pend = 3'h0;
            st_d.c_busy = 1'b0;
         end else begin
            st_d.pend = st_q.pend | evt; // R11
         end
      end else begin
         st_d.flg = st_q.flg | evt; // R8
      end
      if (st_q.as_p && !as_s) begin
         st_d.addr = ad_s[6:0];
      end
      // read data is caught once and held for the whole strobe
      if (rd_go) begin
         st_d.rdata = rd_val; // R10
         st_d.c_busy = st_q.addr == `RTCCA_OFS_FLAGS;
         st_d.snap = st_q.flg;
      end
      if (wr_go) begin
         if (st_q.addr < `RTCCA_OFS_CTRL_A) begin
            st_d.usr[st_q.addr[3:0]] = wv;
            if (!st_q.regb[`RTCCA_B_SET]) begin
               st_d.itn[st_q.addr[3:0]] = wv;
            end
         end else if (st_q.addr == `RTCCA_OFS_CTRL_A) begin
            st_d.rega = ad_s[6:0];
         end else if (st_q.addr == `RTCCA_OFS_CTRL_B) begin
            st_d.regb = ad_s;
            if (ad_s[`RTCCA_B_SET]) begin
               st_d.regb[`RTCCA_B_UIE] = 1'b0; // R24
            end else if (st_q.regb[`RTCCA_B_SET]) begin
               // releasing inhibit hands the host copy to the counter
               st_d.itn = st_d.usr; // R18
            end
         end else if (st_q.addr >= `RTCCA_OFS_NV) begin
            st_d.nv[7'(st_q.addr - `RTCCA_OFS_NV)] = ad_s; // R7
         end
         // flag and battery bytes ignore writes // R26
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         st_q <= ST_RST; // R25
      end else begin
         st_q <= st_d;
      end
   end

   assign AD_O = st_q.rdata;
   assign AD_OE = sel && !rd_s;
   assign IRQ_N_O = 1'b0;
   assign IRQ_OE = irq; // R12
   assign SQUARE_WAVE_OUT = st_q.square_wave_out;

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RST_N);

   AST_FLAG_POST: assert property ( // R8
      !st_q.c_busy && evt[2] |=> st_q.flg[2])
      else $error("periodic event did not set its flag");

   AST_READ_HOLD: assert property ( // R11
      st_q.c_busy && !rd_end && evt[1] && !st_q.flg[1]
      |=> st_q.pend[1] && !st_q.flg[1])
      else $error("alarm event during flag read not held");

   AST_READ_POST: assert property ( // R11
      st_q.c_busy && rd_end && st_q.pend[1] |=> st_q.flg[1])
      else $error("held event not posted after flag read");

   AST_READ_CLEAR: assert property ( // R10
      st_q.c_busy && rd_end && st_q.snap[0] && !st_q.pend[0] && !evt[0]
      |=> !st_q.flg[0])
      else $error("update flag not cleared by flag read");

   AST_SNAP_STABLE: assert property ( // R10
      st_q.c_busy && !rd_end |=> $stable(AD_O))
      else $error("flag read data moved during the read");

   AST_IRQ_ON_ENABLE: assert property ( // R9
      $rose(st_q.regb[`RTCCA_B_PIE]) && st_q.flg[2] |-> IRQ_OE)
      else $error("request not raised on enable of set flag");

   AST_REQUEST_SUMMARY_FLAG_BIT: assert property ( // R12
      rd_go && st_q.addr == `RTCCA_OFS_FLAGS |=> AD_O[7] == $past(IRQ_OE))
      else $error("summary bit differs from request output");

   AST_UIE_CLEAR: assert property ( // R24
      wr_go && st_q.addr == `RTCCA_OFS_CTRL_B && ad_s[`RTCCA_B_SET]
      |=> !st_q.regb[`RTCCA_B_UIE])
      else $error("inhibit did not clear update-ended enable");

   AST_SQW_GATE: assert property ( // R15
      !st_q.regb[`RTCCA_B_SQUARE_WAVE_ENABLE] |=> !SQUARE_WAVE_OUT)
      else $error("square wave active while disabled");

   AST_UIP_LEAD: assert property ( // R20
      upd && !st_q.regb[`RTCCA_B_SET] && $past(run, 7) &&
      !$past(st_q.regb[`RTCCA_B_SET], 7) |-> $past(update_pending_status, 7))
      else $error("update came without the pending lead");

   AST_OSC_STOP: assert property ( // R13
      !run && !hold |=> $stable(st_q.div))
      else $error("divider moved with oscillator stopped");

   AST_ALARM_ALL: assert property ( // R3
      upd && !st_q.c_busy && nxt[`RTCCA_OFS_SEC_ALM][7:6] == 2'h3 &&
      nxt[`RTCCA_OFS_MIN_ALM][7:6] == 2'h3 &&
      nxt[`RTCCA_OFS_HOUR_ALM][7:6] == 2'h3 |=> st_q.flg[1])
      else $error("all-wildcard alarm did not fire");

   AST_FREEZE: assert property ( // R18
      st_q.regb[`RTCCA_B_SET] && !wr_go |=> $stable(st_q.usr))
      else $error("host copy changed while inhibited");

   AST_UPDATE_FLAG: assert property ( // R19
      upd && !st_q.c_busy |=> st_q.flg[0])
      else $error("update-ended flag not set");

   AST_UIP_INHIBIT: assert property ( // R20
      rd_go && st_q.addr == `RTCCA_OFS_CTRL_A && st_q.regb[`RTCCA_B_SET]
      |=> !AD_O[7])
      else $error("update pending read high while inhibited");

   AST_HOLD_DIV: assert property ( // R13
      hold |=> st_q.div == `RTCCA_DIV_HALF)
      else $error("divider not parked while chain held");

   AST_NV_WRITE: assert property ( // R7
      wr_go && st_q.addr >= `RTCCA_OFS_NV
      |=> st_q.nv[7'($past(st_q.addr) - `RTCCA_OFS_NV)] == $past(ad_s))
      else $error("storage byte write did not land");

   AST_FLAG_RO: assert property ( // R26
      wr_go && st_q.addr == `RTCCA_OFS_FLAGS && !st_q.c_busy &&
      evt == 3'h0 |=> st_q.flg == $past(st_q.flg))
      else $error("write changed the flag register");

   AST_WDAY_RANGE: assert property ( // R6
      upd && st_q.itn[`RTCCA_OFS_WDAY] >= 8'h01 &&
      st_q.itn[`RTCCA_OFS_WDAY] <= 8'h07
      |=> st_q.itn[`RTCCA_OFS_WDAY] >= 8'h01 &&
      st_q.itn[`RTCCA_OFS_WDAY] <= 8'h07)
      else $error("weekday left its range");

   AST_SEC_RANGE: assert property ( // R5
      upd && st_q.regb[`RTCCA_B_BIN] && st_q.itn[`RTCCA_OFS_SEC] < 8'h3c
      |=> st_q.itn[`RTCCA_OFS_SEC] < 8'h3c)
      else $error("binary seconds left their range");

   AST_RD_DATA: assert property ( // R10
      rd_go |=> AD_O == $past(rd_val))
      else $error("read data not caught at read start");

   COV_UPDATE: cover property (upd);
   COV_ALARM: cover property (evt[1] && st_q.regb[`RTCCA_B_AIE]);
   COV_FLAG_READ: cover property (st_q.c_busy && rd_end);
   COV_PERIODIC_IRQ: cover property (evt[2] ##1 IRQ_OE);
   COV_UIP: cover property ($rose(update_pending_status));
endmodule : rtcca_core

// [core/rtcca_params.svh]
// offsets, fields, reset values and timing of the rtc calendar core
`ifndef RTCCA_PARAMS_SVH
`define RTCCA_PARAMS_SVH
`define RTCCA_OFS_SEC 7'h00
`define RTCCA_OFS_SEC_ALM 7'h01
`define RTCCA_OFS_MIN 7'h02
`define RTCCA_OFS_MIN_ALM 7'h03
`define RTCCA_OFS_HOUR 7'h04
`define RTCCA_OFS_HOUR_ALM 7'h05
`define RTCCA_OFS_WDAY 7'h06
`define RTCCA_OFS_DATE 7'h07
`define RTCCA_OFS_MONTH 7'h08
`define RTCCA_OFS_YEAR 7'h09
`define RTCCA_OFS_CTRL_A 7'h0a
`define RTCCA_OFS_CTRL_B 7'h0b
`define RTCCA_OFS_FLAGS 7'h0c
`define RTCCA_OFS_BATT 7'h0d
`define RTCCA_OFS_NV 7'h0e
`define RTCCA_NV_BYTES 114
`define RTCCA_TIME_BYTES 10
`define RTCCA_A_UIP 7
`define RTCCA_B_SET 7
`define RTCCA_B_PIE 6
`define RTCCA_B_AIE 5
`define RTCCA_B_UIE 4
`define RTCCA_B_SQUARE_WAVE_ENABLE 3
`define RTCCA_B_BIN 2
`define RTCCA_B_H24 1
`define RTCCA_DV_RUN 3'h2
`define RTCCA_DV_HOLD 2'h3
`define RTCCA_RST_CTRL_A 7'h20
`define RTCCA_RST_CTRL_B 8'h02
`define RTCCA_RST_TIME 80'h0001_0101_0000_0000_0000
`define RTCCA_BATT_OK 8'h80
`define RTCCA_PIN_IDLE 12'h0700
`define RTCCA_DIV_HALF 15'h4000
`define RTCCA_DIV_LAST 15'h7fff
`define RTCCA_CLK_HZ 100000000
`define RTCCA_XTAL_HZ 32768
`define RTCCA_UIP_LEAD_US 244
`define RTCCA_UIP_LEAD_TICKS \
   ((`RTCCA_UIP_LEAD_US * `RTCCA_XTAL_HZ + 999999) / 1000000)
`endif

// [core/rtcca_pkg.sv]
// types of the rtc calendar core
`include "rtcca_params.svh"
package rtcca_pkg;
   typedef struct packed {
      logic [11:0] s1;
      logic [11:0] s2;
   } rtcca_sync_t;

   typedef struct packed {
      logic [`RTCCA_NV_BYTES-1:0][7:0] nv;
      logic [`RTCCA_TIME_BYTES-1:0][7:0] usr;
      logic [`RTCCA_TIME_BYTES-1:0][7:0] itn;
      logic [6:0] rega;
      logic [7:0] regb;
      logic [2:0] flg;
      logic [2:0] pend;
      logic [2:0] snap;
      logic c_busy;
      logic [6:0] addr;
      logic [7:0] rdata;
      logic [26:0] acc;
      logic [14:0] div;
      logic as_p;
      logic rd_p;
      logic wr_p;
      logic tap_p;
      logic square_wave_out;
   } rtcca_state_t;
endpackage : rtcca_pkg

// [core/rtcca_sync.sv]
// two-flop synchroniser for the host bus pins
`timescale 1ns/10ps
`include "rtcca_params.svh"
module rtcca_sync (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // raw pins in, retimed pins out
   input wire logic [11:0] d,
   output logic [11:0] q
);
   rtcca_pkg::rtcca_sync_t r_q;
   rtcca_pkg::rtcca_sync_t r_d;

   always_comb begin
      r_d.s1 = d;
      r_d.s2 = r_q.s1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_q <= {`RTCCA_PIN_IDLE, `RTCCA_PIN_IDLE};
      end else begin
         r_q <= r_d;
      end
   end

   assign q = r_q.s2;
endmodule : rtcca_sync

// [sim/rtcca_core_tb.sv]
// self-checking bench for the rtc calendar core
`timescale 1ns/10ps
`include "rtcca_params.svh"
`define CHK(what, exp, got) \
   begin \
      compares++; \
      if ((got) !== (exp)) begin \
         n_errors++; \
         $display("MISMATCH %s expected %h seen %h", what, exp, got); \
      end \
   end
module rtcca_core_tb;
   logic mclk;
   logic rst_n;
   wire [7:0] ad_i;
   wire [7:0] ad_o;
   wire ad_oe;
   wire as_s;
   wire cs_n;
   wire rd_n;
   wire wr_n;
   wire irq_n_o;
   wire irq_oe;
   wire irq_n;
   wire square_wave_out;
   int n_errors = 0;
   int compares = 0;
   logic [7:0] tv [10];
   logic [7:0] ev [10];
   int hi;
   // one tick per clock: a second is 32768 cycles
   rtcca_core #(.TICK_STEP(100000000)) i_rtcca_core (
      .MCLK(mclk), .RST_N(rst_n), .AD_I(ad_i), .AD_O(ad_o),
      .AD_OE(ad_oe), .AS(as_s), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
      .IRQ_N_O(irq_n_o), .IRQ_OE(irq_oe), .SQUARE_WAVE_OUT(square_wave_out));
   rtcca_host i_rtcca_host (
      .clk(mclk), .ad_to_dev(ad_i), .ad_from_dev(ad_o), .ad_oe(ad_oe),
      .as_o(as_s), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
      .irq_n_o(irq_n_o), .irq_oe(irq_oe), .irq_n(irq_n));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic wrap_up;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : wrap_up
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      i_rtcca_host.wr(a, d);
   endtask : wr
   task automatic chk_rd(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] d;
      i_rtcca_host.rd(a, d);
      `CHK($sformatf("reg %h", a), exp, d)
   endtask : chk_rd
   task automatic cyc(input int n);
      i_rtcca_host.cyc(n);
   endtask : cyc
   // chain held while loading, so no update lands mid-write
   task automatic load_time(input logic [7:0] b);
      wr(`RTCCA_OFS_CTRL_A, 8'h60);
      wr(`RTCCA_OFS_CTRL_B, b | 8'h80);
      for (int i = 0; i < 10; i++) begin
         wr(7'(i), tv[i]);
      end
      wr(`RTCCA_OFS_CTRL_B, b);
      wr(`RTCCA_OFS_CTRL_A, 8'h20);
   endtask : load_time
   task automatic chk_time;
      for (int i = 0; i < 10; i++) begin
         chk_rd(7'(i), ev[i]);
      end
   endtask : chk_time
   task automatic count_sqw;
      hi = 0;
      for (int i = 0; i < 64; i++) begin
         cyc(1);
         hi += int'(square_wave_out === 1'b1);
      end
   endtask : count_sqw
   initial begin
      #800000;
      n_errors++;
      wrap_up();
   end
   initial begin
      int n;
      rst_n = 1'b0;
      repeat (4) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      cyc(5);
      `CHK("irq line", 1'b1, irq_n)
      `CHK("sqw", 1'b0, square_wave_out)
      for (int i = 0; i < 10; i++) begin
         chk_rd(7'(i), 8'(`RTCCA_RST_TIME >> (8 * i)));
      end
      chk_rd(`RTCCA_OFS_CTRL_A, 8'h20);
      chk_rd(`RTCCA_OFS_CTRL_B, 8'h02);
      wr(`RTCCA_OFS_FLAGS, 8'hff);
      wr(`RTCCA_OFS_BATT, 8'h00);
      chk_rd(`RTCCA_OFS_FLAGS, 8'h00);
      chk_rd(`RTCCA_OFS_BATT, 8'h80);
      wr(`RTCCA_OFS_NV, 8'ha5);
      wr(7'h7f, 8'h3c);
      chk_rd(`RTCCA_OFS_NV, 8'ha5);
      chk_rd(7'h7f, 8'h3c);
      // bcd, 24 h, year end rollover, all alarm bytes wildcards
      tv = '{8'h59, 8'hc0, 8'h59, 8'hff, 8'h23, 8'hd5, 8'h07, 8'h31,
         8'h12, 8'h99};
      ev = '{8'h00, 8'hc0, 8'h00, 8'hff, 8'h00, 8'hd5, 8'h01, 8'h01,
         8'h01, 8'h00};
      load_time(8'h22);
      n = 0;
      while (irq_n !== 1'b0 && n < 17000) begin
         cyc(1);
         n++;
      end
      `CHK("irq line", 1'b0, irq_n)
      chk_time();
      chk_rd(`RTCCA_OFS_FLAGS, 8'hb0);
      `CHK("irq line", 1'b1, irq_n)
      chk_rd(`RTCCA_OFS_FLAGS, 8'h00);
      // binary, 12 h pm rollover, leap february, explicit alarm
      tv = '{8'h3b, 8'h00, 8'h3b, 8'h00, 8'h8b, 8'h0c, 8'h03, 8'h1c,
         8'h02, 8'h04};
      ev = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0c, 8'h0c, 8'h04, 8'h1d,
         8'h02, 8'h04};
      load_time(8'h04);
      cyc(16400);
      `CHK("irq line", 1'b1, irq_n)
      chk_time();
      wr(`RTCCA_OFS_CTRL_B, 8'h24);
      cyc(2);
      `CHK("irq line", 1'b0, irq_n)
      chk_rd(`RTCCA_OFS_FLAGS, 8'hb0);
      // inhibit: host copy frozen while updates still end
      wr(`RTCCA_OFS_CTRL_B, 8'h94);
      chk_rd(`RTCCA_OFS_CTRL_B, 8'h84);
      wr(`RTCCA_OFS_CTRL_A, 8'h60);
      wr(`RTCCA_OFS_CTRL_A, 8'h20);
      cyc(16400);
      chk_rd(`RTCCA_OFS_SEC, 8'h00);
      chk_rd(`RTCCA_OFS_FLAGS, 8'h10);
      chk_rd(`RTCCA_OFS_CTRL_A, 8'h20);
      wr(`RTCCA_OFS_CTRL_B, 8'h04);
      // rate 3 taps divider bit 1: four cycle period
      wr(`RTCCA_OFS_CTRL_A, 8'h23);
      wr(`RTCCA_OFS_CTRL_B, 8'h0c);
      count_sqw();
      `CHK("sqw high cycles", 32, hi)
      `CHK("irq line", 1'b1, irq_n)
      chk_rd(`RTCCA_OFS_FLAGS, 8'h40);
      wr(`RTCCA_OFS_CTRL_B, 8'h44);
      cyc(2);
      `CHK("irq line", 1'b0, irq_n)
      count_sqw();
      `CHK("sqw high cycles", 0, hi)
      chk_rd(`RTCCA_OFS_FLAGS, 8'hc0);
      // oscillator stopped: chain frozen, no periodic edges
      wr(`RTCCA_OFS_CTRL_A, 8'h03);
      i_rtcca_host.rd(`RTCCA_OFS_FLAGS, tv[0]);
      chk_rd(`RTCCA_OFS_FLAGS, 8'h00);
      // rate zero: no periodic events; first read drops a stray one
      wr(`RTCCA_OFS_CTRL_A, 8'h20);
      wr(`RTCCA_OFS_CTRL_B, 8'h04);
      i_rtcca_host.rd(`RTCCA_OFS_FLAGS, tv[0]);
      chk_rd(`RTCCA_OFS_FLAGS, 8'h00);
      // reset in mid-run with the request asserted
      wr(`RTCCA_OFS_CTRL_A, 8'h23);
      wr(`RTCCA_OFS_CTRL_B, 8'h44);
      `CHK("irq line", 1'b0, irq_n)
      rst_n = 1'b0;
      cyc(4);
      `CHK("irq line", 1'b1, irq_n)
      rst_n = 1'b1;
      cyc(5);
      chk_rd(`RTCCA_OFS_FLAGS, 8'h00);
      wrap_up();
   end
endmodule : rtcca_core_tb

// [sim/rtcca_host.sv]
// host processor model driving the multiplexed bus of the core
`timescale 1ns/10ps
module rtcca_host (
   // clock
   input wire logic clk,
   // bus towards the core
   output logic [7:0] ad_to_dev,
   input wire logic [7:0] ad_from_dev,
   input wire logic ad_oe,
   output logic as_o,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   // open-drain request, pulled up here
   input wire logic irq_n_o,
   input wire logic irq_oe,
   output logic irq_n
);
   logic host_oe = 1'b0;
   logic [7:0] host_d = 8'h00;
   logic [7:0] float_q = 8'h5a;
   // released bus never keeps the last value
   assign ad_to_dev = ad_oe ? ad_from_dev : (host_oe ? host_d : float_q);
   assign irq_n = irq_oe ? irq_n_o : 1'b1;
   always @(posedge clk) float_q <= ~ad_to_dev;
   initial begin
      as_o = 1'b0;
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   // strobes held at least 3 cycles so the two-flop sync sees every level
   task automatic addr_phase(input logic [6:0] a);
      host_d = {1'b0, a};
      host_oe = 1'b1;
      as_o = 1'b1;
      cyc(3);
      as_o = 1'b0;
      cyc(3);
   endtask : addr_phase
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      addr_phase(a);
      host_d = d;
      cs_n = 1'b0;
      wr_n = 1'b0;
      cyc(4);
      wr_n = 1'b1;
      cyc(3);
      cs_n = 1'b1;
      host_oe = 1'b0;
      cyc(3);
   endtask : wr
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      int n;
      addr_phase(a);
      host_oe = 1'b0;
      cs_n = 1'b0;
      rd_n = 1'b0;
      n = 0;
      while (ad_oe !== 1'b1 && n < 20) begin
         cyc(1);
         n++;
      end
      cyc(2);
      d = ad_oe ? ad_to_dev : 8'hxx;
      rd_n = 1'b1;
      cyc(3);
      cs_n = 1'b1;
      cyc(3);
   endtask : rd
endmodule : rtcca_host
